/* core/nvm_ctrl.sv */
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module nvm_ctrl #(
  parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES
) (
  input  wire logic                            clock_i,
  input  wire logic                            srst_i,
  input  wire logic [3:0]                      addr_i,
  input  wire logic [7:0]                      wdata_i,
  input  wire logic                            wr_i,
  input  wire logic                            rd_i,
  output logic      [7:0]                      rdata_o,
  output logic                                 irq_o,
  output logic                                 stall_o,
  output logic      [nvm_pkg::PROG_ADDR_W-1:0] prog_addr_o,
  input  wire logic [nvm_pkg::PROG_DATA_W-1:0] prog_data_i,
  output logic      [7:0]                      ee_addr_o,
  output logic      [7:0]                      ee_wdata_o,
  output logic                                 ee_write_o,
  input  wire logic [7:0]                      ee_rdata_i
);

  localparam int CW = $clog2(WRITE_CYCLES + 1);

  nvm_pkg::reg_req_t req;
  logic [7:0]        addr_low;
  logic [3:0]        addr_high;
  logic [7:0]        data_low;
  logic [5:0]        data_high;
  logic              space_select;
  logic              write_permit;
  logic              write_go;
  logic              write_error;
  logic              write_done_flag;
  logic              done_mask;
  logic              armed;
  logic              go_req;
  logic              start_write;
  logic              end_write;
  logic              prog_pending;
  logic              prog_fetch;
  logic              data_read;
  logic [CW-1:0]     write_count;

  assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

  function automatic logic hit(input nvm_pkg::reg_req_t r,
                               input logic [3:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  //--------------------------------------------------------------------------
  // Unlock sequence
  //--------------------------------------------------------------------------
  nvm_unlock u_unlock (
    .clock_i       (clock_i),
    .srst_i        (srst_i),
    .unlock_wr_i   (hit(req, nvm_pkg::UNLOCK_OFS)),
    .unlock_data_i (req.wdata),
    // A go attempt uses up the unlock, so every byte needs a fresh sequence
    .other_wr_i    (req.wr && req.addr != nvm_pkg::UNLOCK_OFS),
    .armed_o       (armed)
  );

  assign go_req = hit(req, nvm_pkg::CONTROL_OFS) &&
                  req.wdata[nvm_pkg::CTL_WRITE_GO];
  // Permit is checked against its value before this write; program space
  // takes the new select value so the go is dropped at once
  assign start_write = go_req && !write_go && armed && write_permit &&
                       !req.wdata[nvm_pkg::CTL_SPACE];
  assign end_write = write_go && (write_count == CW'(WRITE_CYCLES - 1));
  assign data_read = hit(req, nvm_pkg::CONTROL_OFS) &&
                     req.wdata[nvm_pkg::CTL_READ_GO] &&
                     !req.wdata[nvm_pkg::CTL_SPACE];
  assign prog_fetch = hit(req, nvm_pkg::CONTROL_OFS) &&
                      req.wdata[nvm_pkg::CTL_READ_GO] &&
                      req.wdata[nvm_pkg::CTL_SPACE];

  //--------------------------------------------------------------------------
  // Address registers
  //--------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      addr_low  <= nvm_pkg::BYTE_RESET;
      addr_high <= 4'h0;
    end else begin
      if (hit(req, nvm_pkg::ADDR_LOW_OFS)) begin
        addr_low <= req.wdata;
      end
      if (hit(req, nvm_pkg::ADDR_HIGH_OFS)) begin
        addr_high <= req.wdata[3:0];
      end
    end
  end

  //--------------------------------------------------------------------------
  // Control register
  //--------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      space_select <= 1'b0;
      write_permit <= 1'b0;
      write_error  <= 1'b0;
    end else if (hit(req, nvm_pkg::CONTROL_OFS)) begin
      space_select <= req.wdata[nvm_pkg::CTL_SPACE];
      write_permit <= req.wdata[nvm_pkg::CTL_PERMIT];
      write_error  <= req.wdata[nvm_pkg::CTL_ERROR];
    end
  end

  //--------------------------------------------------------------------------
  // Write cycle timer
  //--------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      write_go    <= 1'b0;
      write_count <= '0;
    end else if (start_write) begin
      write_go    <= 1'b1;
      write_count <= '0;
    end else if (end_write) begin
      write_go    <= 1'b0;
      write_count <= '0;
    end else if (write_go) begin
      write_count <= write_count + CW'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ee_write_o <= 1'b0;
      ee_addr_o  <= nvm_pkg::BYTE_RESET;
      ee_wdata_o <= nvm_pkg::BYTE_RESET;
    end else begin
      ee_write_o <= start_write;
      // Follow a fresh address write at once so a back-to-back read sees it
      if (hit(req, nvm_pkg::ADDR_LOW_OFS)) begin
        ee_addr_o <= req.wdata;
      end else begin
        ee_addr_o <= addr_low;
      end
      if (start_write) begin
        ee_wdata_o <= data_low;
      end
    end
  end

  //--------------------------------------------------------------------------
  // Program read stall: second cycle after read-go is the flash access
  //--------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prog_pending <= 1'b0;
      stall_o      <= 1'b0;
      prog_addr_o  <= '0;
    end else begin
      prog_pending <= prog_fetch;
      stall_o      <= prog_pending;
      if (prog_fetch) begin
        prog_addr_o <= {addr_high, addr_low};
      end
    end
  end

  //--------------------------------------------------------------------------
  // Data registers
  //--------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      data_low  <= nvm_pkg::BYTE_RESET;
      data_high <= 6'h00;
    end else if (stall_o) begin
      data_low  <= prog_data_i[7:0];
      data_high <= prog_data_i[13:8];
    end else if (data_read) begin
      data_low <= ee_rdata_i;
    end else begin
      if (hit(req, nvm_pkg::DATA_LOW_OFS)) begin
        data_low <= req.wdata;
      end
      if (hit(req, nvm_pkg::DATA_HIGH_OFS)) begin
        data_high <= req.wdata[5:0];
      end
    end
  end

  //--------------------------------------------------------------------------
  // Interrupt status and mask
  //--------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      write_done_flag <= 1'b0;
      done_mask       <= 1'b0;
    end else begin
      if (end_write) begin
        write_done_flag <= 1'b1;
      end else if (hit(req, nvm_pkg::IRQ_STATUS_OFS) &&
                   req.wdata[nvm_pkg::IRQ_DONE]) begin
        write_done_flag <= 1'b0;
      end
      if (hit(req, nvm_pkg::IRQ_MASK_OFS)) begin
        done_mask <= req.wdata[nvm_pkg::IRQ_DONE];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (write_done_flag || end_write) && done_mask;
    end
  end

  //--------------------------------------------------------------------------
  // Read data, one cycle after the strobe
  //--------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= nvm_pkg::BYTE_RESET;
    end else if (req.rd) begin
      unique case (req.addr)
        nvm_pkg::ADDR_LOW_OFS:   rdata_o <= addr_low;
        nvm_pkg::ADDR_HIGH_OFS:  rdata_o <= {4'h0, addr_high};
        nvm_pkg::DATA_LOW_OFS:   rdata_o <= data_low;
        nvm_pkg::DATA_HIGH_OFS:  rdata_o <= {2'h0, data_high};
        nvm_pkg::CONTROL_OFS:    rdata_o <= {space_select, 3'h0, write_error,
                                             write_permit, write_go, 1'b0};
        nvm_pkg::IRQ_STATUS_OFS: rdata_o <= {7'h00, write_done_flag};
        nvm_pkg::IRQ_MASK_OFS:   rdata_o <= {7'h00, done_mask};
        default:                 rdata_o <= nvm_pkg::BYTE_RESET;
      endcase
    end else begin
      rdata_o <= nvm_pkg::BYTE_RESET;
    end
  end

  //--------------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------------
  go_needs_permit_a: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(write_go) |-> $past(write_permit) && $past(armed))
    else $error("write-go set without permit or unlock");

  permit_sw_only_a: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(write_permit) |-> $past(hit(req, nvm_pkg::CONTROL_OFS)))
    else $error("write-permit cleared by hardware");

  cycle_length_a: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(write_go) |-> write_go [*8])
    else $error("write cycle ended early");

  done_sets_a: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(write_go) |-> write_done_flag)
    else $error("done flag not set at write end");

  done_sticky_a: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(write_done_flag) |-> $past(hit(req, nvm_pkg::IRQ_STATUS_OFS)))
    else $error("done flag cleared without software");

  prog_stall_a: assert property (@(posedge clock_i) disable iff (srst_i)
    prog_fetch |-> ##1 !stall_o ##1 stall_o ##1 !stall_o)
    else $error("program read stall misplaced");

  prog_word_a: assert property (@(posedge clock_i) disable iff (srst_i)
    stall_o |=> data_low == $past(prog_data_i[7:0]) &&
                data_high == $past(prog_data_i[13:8]))
    else $error("program word not captured");

  prog_space_go_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (go_req && req.wdata[nvm_pkg::CTL_SPACE] && !write_go) |=> !write_go)
    else $error("write-go held in program space");

  ee_read_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (data_read && !stall_o) |=> data_low == $past(ee_rdata_i))
    else $error("data read byte missing");

endmodule

/* core/nvm_pkg.sv */
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package nvm_pkg;

  //--------------------------------------------------------------------------
  // Register offsets
  //--------------------------------------------------------------------------
  localparam logic [3:0] ADDR_LOW_OFS   = 4'h0;
  localparam logic [3:0] ADDR_HIGH_OFS  = 4'h1;
  localparam logic [3:0] DATA_LOW_OFS   = 4'h2;
  localparam logic [3:0] DATA_HIGH_OFS  = 4'h3;
  localparam logic [3:0] CONTROL_OFS    = 4'h4;
  localparam logic [3:0] UNLOCK_OFS     = 4'h5;
  localparam logic [3:0] IRQ_STATUS_OFS = 4'h6;
  localparam logic [3:0] IRQ_MASK_OFS   = 4'h7;

  //--------------------------------------------------------------------------
  // Control bit positions
  //--------------------------------------------------------------------------
  localparam int CTL_READ_GO  = 0;
  localparam int CTL_WRITE_GO = 1;
  localparam int CTL_PERMIT   = 2;
  localparam int CTL_ERROR    = 3;
  localparam int CTL_SPACE    = 7;
  localparam int IRQ_DONE     = 0;

  //--------------------------------------------------------------------------
  // Unlock values, reset values and timing
  //--------------------------------------------------------------------------
  localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [7:0] BYTE_RESET    = 8'h00;
  localparam int         CLOCK_HZ      = 40_000_000;
  localparam int         WRITE_TIME_US = 5000;
  localparam int         WRITE_CYCLES  = WRITE_TIME_US * (CLOCK_HZ / 1_000_000);
  localparam int         PROG_ADDR_W   = 12;
  localparam int         PROG_DATA_W   = 14;

  typedef enum logic [1:0] {
    UNLOCK_IDLE,
    UNLOCK_GOT_FIRST,
    UNLOCK_ARMED
  } unlock_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

/* core/nvm_unlock.sv */
`timescale 1ns/1ps
module nvm_unlock (
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  input  wire logic       unlock_wr_i,
  input  wire logic [7:0] unlock_data_i,
  input  wire logic       other_wr_i,
  output logic            armed_o
);

  nvm_pkg::unlock_state_t state;
  nvm_pkg::unlock_state_t next_state;

  //--------------------------------------------------------------------------
  // Sequence tracker: any other register write breaks the sequence
  //--------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (unlock_wr_i) begin
      if (unlock_data_i == nvm_pkg::UNLOCK_FIRST) begin
        next_state = nvm_pkg::UNLOCK_GOT_FIRST;
      end else if (unlock_data_i == nvm_pkg::UNLOCK_SECOND &&
                   state == nvm_pkg::UNLOCK_GOT_FIRST) begin
        next_state = nvm_pkg::UNLOCK_ARMED;
      end else begin
        next_state = nvm_pkg::UNLOCK_IDLE;
      end
    end else if (other_wr_i) begin
      next_state = nvm_pkg::UNLOCK_IDLE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= nvm_pkg::UNLOCK_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign armed_o = (state == nvm_pkg::UNLOCK_ARMED);

  arm_order_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (state == nvm_pkg::UNLOCK_ARMED && !$past(srst_i)) |->
    $past(unlock_wr_i) && $past(unlock_data_i) == nvm_pkg::UNLOCK_SECOND ||
    $past(state) == nvm_pkg::UNLOCK_ARMED)
    else $error("unlock armed without AAh");

endmodule

/* dv/nvm_mem_model.sv */
`timescale 1ns/1ps
module nvm_mem_model (
  input  wire logic [nvm_pkg::PROG_ADDR_W-1:0] prog_addr_i,
  output logic      [nvm_pkg::PROG_DATA_W-1:0] prog_data_o,
  input  wire logic                            clock_i,
  input  wire logic [7:0]                      ee_addr_i,
  input  wire logic [7:0]                      ee_wdata_i,
  input  wire logic                            ee_write_i,
  output logic      [7:0]                      ee_rdata_o
);
  //--------------------------------------------------------------------------
  // Storage
  //--------------------------------------------------------------------------
  logic [7:0] cells [256];

  initial begin
    for (int i = 0; i < 256; i++) begin
      cells[i] = 8'(i) ^ 8'h5A;
    end
  end

  // Flash word is a fixed function of its address
  assign prog_data_o = {prog_addr_i, 2'h1} ^ 14'h2A5C;
  assign ee_rdata_o  = cells[ee_addr_i];

  always @(posedge clock_i) begin
    if (ee_write_i) begin
      cells[ee_addr_i] <= ee_wdata_i;
    end
  end
endmodule

/* dv/tb_nvm_ctrl.sv */
`timescale 1ns/1ps
module tb_nvm_ctrl;
  localparam int WC = 10;
  logic                            clock_i;
  logic                            srst_i;
  logic                            wr_i;
  logic                            rd_i;
  logic                            irq_o;
  logic                            stall_o;
  logic                            ee_write_o;
  logic [3:0]                      addr_i;
  logic [7:0]                      wdata_i;
  logic [7:0]                      rdata_o;
  logic [7:0]                      ee_addr_o;
  logic [7:0]                      ee_wdata_o;
  logic [7:0]                      ee_rdata_i;
  logic [nvm_pkg::PROG_ADDR_W-1:0] prog_addr_o;
  logic [nvm_pkg::PROG_DATA_W-1:0] prog_data_i;
  int                              n_mismatch;
  int                              checks_done;
  int                              cycles;
  int                              unl;
  int                              busy;
  int                              regs [8];
  int                              ee [256];

  nvm_ctrl #(.WRITE_CYCLES(WC)) nvm_ctrl_i (
    .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .stall_o(stall_o), .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i),
    .ee_addr_o(ee_addr_o), .ee_wdata_o(ee_wdata_o), .ee_write_o(ee_write_o),
    .ee_rdata_i(ee_rdata_i));

  nvm_mem_model nvm_mem_model_i (
    .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i), .clock_i(clock_i),
    .ee_addr_i(ee_addr_o), .ee_wdata_i(ee_wdata_o), .ee_write_i(ee_write_o),
    .ee_rdata_o(ee_rdata_i));

  //--------------------------------------------------------------------------
  // Compare and closing tasks
  //--------------------------------------------------------------------------
  task automatic cmp_byte(input string what, input int exp,
                          input logic [7:0] seen);
    checks_done++;
    if (seen !== 8'(exp)) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cmp_bit(input string what, input int exp, input logic seen);
    checks_done++;
    if (seen !== 1'(exp)) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  //--------------------------------------------------------------------------
  // Bus tasks with the reference model folded in
  //--------------------------------------------------------------------------
  task automatic bus_wr(input logic [3:0] ofs, input int d);
    int pw;
    @(posedge clock_i);
    addr_i  <= ofs;
    wdata_i <= 8'(d);
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    d  = d & 'hFF;
    pw = ((regs[1] << 10) | (regs[0] << 2) | 1) ^ 'h2A5C;
    case (ofs)
      4'h0: regs[0] = d;
      4'h1: regs[1] = d & 'hF;
      4'h2: regs[2] = d;
      4'h3: regs[3] = d & 'h3F;
      4'h4: begin
        if ((d & 2) && unl == 2 && (regs[4] & 4) && !(d & 'h80) && !busy) begin
          busy    = 1;
          regs[4] = regs[4] | 2;
          ee[regs[0]] = regs[2];
        end
        regs[4] = (d & 'h8C) | (regs[4] & 2);
        if ((d & 1) && (d & 'h80)) begin
          regs[2] = pw & 'hFF;
          regs[3] = pw >> 8;
        end else if (d & 1) begin
          regs[2] = ee[regs[0]];
        end
      end
      4'h5: unl = (d == 'h55) ? 1 : (d == 'hAA && unl == 1) ? 2 : 0;
      4'h6: regs[6] = (d & 1) ? 0 : regs[6];
      4'h7: regs[7] = d & 1;
      default: ;
    endcase
    if (ofs != 4'h5) begin
      unl = 0;
    end
  endtask

  task automatic bus_rd(input logic [3:0] ofs, input string what);
    @(posedge clock_i);
    addr_i <= ofs;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    cmp_byte(what, ofs[3] ? 0 : regs[ofs[2:0]], rdata_o);
  endtask

  task automatic wait_done();
    repeat (WC + 4) @(posedge clock_i);
    if (busy) begin
      busy    = 0;
      regs[4] = regs[4] & 'hFD;
      regs[6] = 1;
    end
  endtask

  task automatic ee_write(input int a, input int d, input int clr);
    bus_wr(4'h0, a);
    bus_wr(4'h2, d);
    bus_wr(4'h5, 'h55);
    bus_wr(4'h5, 'hAA);
    bus_wr(4'h4, 'h06);
    bus_rd(4'h4, "busy_control");
    if (clr) begin
      bus_wr(4'h4, 'h00);
    end
    wait_done();
    bus_rd(4'h4, "end_control");
    bus_rd(4'h6, "done_flag");
    cmp_bit("irq", regs[6] & regs[7], irq_o);
  endtask

  //--------------------------------------------------------------------------
  // Clock, timeout and main sequence
  //--------------------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    int a1;
    int a2;
    srst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    {n_mismatch, checks_done, cycles, unl, busy} = '0;
    foreach (regs[i]) regs[i] = 0;
    foreach (ee[i]) ee[i] = i ^ 'h5A;
    void'($urandom(32'h925f));
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    for (int o = 0; o < 8; o++) bus_rd(4'(o), "reset_value");
    bus_wr(4'hC, $urandom);
    bus_rd(4'hC, "unmapped");
    for (int o = 0; o < 8; o++) bus_wr(4'(o % 4 + (o / 4) * 7), $urandom);
    for (int o = 0; o < 8; o++) bus_rd(4'(o), "reg_rw");
    bus_wr(4'h6, 'h01);
    bus_wr(4'h4, 'h88);
    bus_rd(4'h4, "control_rw");
    bus_wr(4'h4, 'h00);
    bus_wr(4'h5, 'h55);
    bus_wr(4'h5, 'hAA);
    bus_wr(4'h4, 'h02);
    bus_rd(4'h4, "go_no_permit");
    bus_wr(4'h4, 'h04);
    for (int k = 0; k < 4; k++) begin
      bus_wr(4'h5, (k == 0) ? 'hAA : 'h55);
      bus_wr(4'(k == 3 ? 0 : 5), (k == 1) ? 'h55 : (k == 2) ? 'h00 : 'hAA);
      bus_wr(4'h4, 'h06);
      bus_rd(4'h4, "bad_unlock");
    end
    wait_done();
    bus_rd(4'h6, "no_done");
    a1 = $urandom & 'hFF;
    a2 = (a1 + 1) & 'hFF;
    bus_wr(4'h7, 'h01);
    ee_write(a1, $urandom, 0);
    bus_wr(4'h4, 'h06);
    bus_rd(4'h4, "go_again");
    repeat (8) @(posedge clock_i);
    bus_rd(4'h6, "done_sticky");
    cmp_bit("irq_held", 1, irq_o);
    bus_wr(4'h6, 'h01);
    bus_rd(4'h6, "done_clear");
    cmp_bit("irq_clear", 0, irq_o);
    bus_wr(4'h7, 'h00);
    ee_write(a2, $urandom, 1);
    bus_wr(4'h6, 'h01);
    for (int k = 0; k < 3; k++) begin
      bus_wr(4'h0, (k == 0) ? a1 : (k == 1) ? a2 : $urandom);
      bus_wr(4'h4, 'h01);
      bus_rd(4'h2, "ee_read");
    end
    bus_wr(4'h4, 'h84);
    bus_wr(4'h5, 'h55);
    bus_wr(4'h5, 'hAA);
    bus_wr(4'h4, 'h86);
    bus_rd(4'h4, "go_prog_space");
    wait_done();
    bus_rd(4'h6, "prog_no_done");
    repeat (2) begin
      bus_wr(4'h1, $urandom);
      bus_wr(4'h0, $urandom);
      bus_wr(4'h4, 'h81);
      #1;
      cmp_bit("stall_first", 0, stall_o);
      @(posedge clock_i);
      #1;
      cmp_bit("stall_second", 1, stall_o);
      @(posedge clock_i);
      #1;
      cmp_bit("stall_after", 0, stall_o);
      bus_rd(4'h2, "prog_low");
      bus_rd(4'h3, "prog_high");
      bus_wr(4'h0, $urandom);
      bus_rd(4'h2, "hold_low");
      bus_rd(4'h3, "hold_high");
      bus_wr(4'h2, $urandom);
      bus_rd(4'h2, "sw_low");
    end
    complete_run();
  end
endmodule
